// ===== src/hblank_regs.svh
// register offsets, field positions, reset values and timing counts of the blanking generator
`ifndef HBLANK_REGS_SVH
`define HBLANK_REGS_SVH

`define OFS_MODE          8'h00
`define OFS_MASK          8'h02
`define OFS_REP_START     8'h04
`define OFS_REP_END       8'h06
`define OFS_REP_LEN       8'h08
`define OFS_REP_COUNT     8'h0a
`define OFS_EVEN_TOG0     8'h10
`define OFS_ODD_TOG0      8'h18
`define OFS_STRETCH       8'h34
`define OFS_START_A       8'h38
`define OFS_START_B       8'h3a
`define OFS_START_C       8'h3c
`define OFS_PIX_BLANK_ON  8'h40
`define OFS_PIX_BLANK_OFF 8'h42
`define OFS_CLAMP_ON      8'h44
`define OFS_CLAMP_OFF     8'h46
`define OFS_ODD_ORDER0    8'h50
`define OFS_COUNT0        8'h60
`define OFS_STATUS        8'h70

`define STRETCH_LSB       4
`define STRETCH_MSB       7
`define CNT_A_LSB         0
`define CNT_B_LSB         4
`define CNT_C_LSB         8
`define MASK_DRV1_BIT     0
`define MASK_DRV2_BIT     1
`define MASK_LAST_BIT     2

`define RST_POS           13'h0000
`define RST_MODE          2'h0
`define RST_MASK          3'h0
`define RST_STRETCH       4'h0
`define PIPE_DLY          4'hc
`define NUM_TOG           6
`define NUM_AREA          6
`define NUM_CNT_WORDS     12

`endif

// ===== src/hblank_pkg.sv
// types shared by the blanking generator and its count memory
package hblank_pkg;
   typedef logic [12:0] pos_t;
   typedef logic [11:0] cnt_word_t;
   typedef logic [3:0]  cnt_addr_t;
   typedef enum logic [1:0] {
      MODE_NORMAL   = 2'b00,
      MODE_REPEAT   = 2'b01,
      MODE_ADVANCED = 2'b10,
      MODE_TEST     = 2'b11
   } blank_mode_t;
endpackage : hblank_pkg

// ===== src/cnt_mem_if.sv
// link between the generator and its per-area pulse count memory
interface cnt_mem_if;
   logic                  wr_en;
   hblank_pkg::cnt_addr_t wr_addr;
   hblank_pkg::cnt_word_t wr_data;
   hblank_pkg::cnt_addr_t rd_addr1;
   hblank_pkg::cnt_addr_t rd_addr2;
   hblank_pkg::cnt_word_t rd_data1;
   hblank_pkg::cnt_word_t rd_data2;
   modport mem  (input wr_en, wr_addr, wr_data, rd_addr1, rd_addr2,
                 output rd_data1, rd_data2);
   modport user (output wr_en, wr_addr, wr_data, rd_addr1, rd_addr2,
                 input rd_data1, rd_data2);
endinterface : cnt_mem_if

// ===== src/area_count_mem.sv
// twelve-word store of per-area pulse counts, two registered read ports
`include "hblank_regs.svh"
module area_count_mem (
   input wire logic   sys_clk,   // pixel clock
   input wire logic   sys_rst,   // synchronous reset, active high
   cnt_mem_if.mem     port       // write and read ports
);
   hblank_pkg::cnt_word_t mem_ff      [`NUM_CNT_WORDS];
   hblank_pkg::cnt_word_t nxt_mem     [`NUM_CNT_WORDS];
   hblank_pkg::cnt_word_t rd1_ff;
   hblank_pkg::cnt_word_t rd2_ff;
   hblank_pkg::cnt_word_t nxt_rd1;
   hblank_pkg::cnt_word_t nxt_rd2;

   // out-of-range address reads zero so a stray area gives no pulses
   function automatic hblank_pkg::cnt_word_t pick(input hblank_pkg::cnt_addr_t a,
                                                  input hblank_pkg::cnt_word_t m [`NUM_CNT_WORDS]);
      pick = (a < 4'(`NUM_CNT_WORDS)) ? m[a] : 12'h000;
   endfunction : pick

   always_comb begin
      nxt_mem = mem_ff;
      if (port.wr_en && port.wr_addr < 4'(`NUM_CNT_WORDS)) begin
         nxt_mem[port.wr_addr] = port.wr_data;
      end
      nxt_rd1 = pick(port.rd_addr1, mem_ff);
      nxt_rd2 = pick(port.rd_addr2, mem_ff);
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < `NUM_CNT_WORDS; i++) begin
            mem_ff[i] <= 12'h000;
         end
         rd1_ff <= 12'h000;
         rd2_ff <= 12'h000;
      end else begin
         mem_ff <= nxt_mem;
         rd1_ff <= nxt_rd1;
         rd2_ff <= nxt_rd2;
      end
   end

   assign port.rd_data1 = rd1_ff;
   assign port.rd_data2 = rd2_ff;
endmodule : area_count_mem

// ===== src/hblank_gen.sv
// horizontal blanking and horizontal clock pattern generator
`include "hblank_regs.svh"
module hblank_gen (
   input  wire logic        sys_clk,          // pixel clock
   input  wire logic        sys_rst,          // synchronous reset, active high
   input  wire logic        line_sync,        // line sync, falling edge starts line
   input  wire logic        reg_wr,           // register write strobe
   input  wire logic        reg_rd,           // register read strobe
   input  wire logic [7:0]  reg_addr,         // register address
   input  wire logic [15:0] reg_wdata,        // write data
   output logic      [15:0] reg_rdata,        // read data, one cycle after reg_rd
   output logic             horizontal_blank, // blanking interval
   output logic             horizontal_driver_1, // driver 1/3
   output logic             horizontal_driver_2, // driver 2/4
   output logic             last_stage_driver, // last stage clock
   output logic             pixel_blank,      // pixel blank
   output logic             black_clamp       // black clamp
);
   typedef hblank_pkg::pos_t pos_t;

   // configuration
   hblank_pkg::blank_mode_t mode_ff, nxt_mode;
   logic [2:0]  mask_ff, nxt_mask;
   logic [3:0]  stretch_ff, nxt_stretch;
   pos_t        rstart_ff, nxt_rstart, rend_ff, nxt_rend, rlen_ff, nxt_rlen, rcnt_ff, nxt_rcnt;
   pos_t        even_tog_ff [`NUM_TOG];
   pos_t        nxt_even_tog [`NUM_TOG];
   pos_t        odd_tog_ff [`NUM_TOG];
   pos_t        nxt_odd_tog [`NUM_TOG];
   pos_t        sa_ff, nxt_sa, sb_ff, nxt_sb, sc_ff, nxt_sc;
   pos_t        pon_ff, nxt_pon, poff_ff, nxt_poff, con_ff, nxt_con, coff_ff, nxt_coff;
   logic [2:0]  order_ff [`NUM_AREA];
   logic [2:0]  nxt_order [`NUM_AREA];
   logic [15:0] rdata_ff, nxt_rdata;

   // timing state
   logic        sync_d_ff, nxt_sync_d;
   logic [3:0]  dly_ff, nxt_dly;
   pos_t        hcnt_ff, nxt_hcnt;
   logic        odd_ff, nxt_odd;
   logic        tog_ff, nxt_tog;
   pos_t        rpos_ff, nxt_rpos;
   pos_t        ridx_ff, nxt_ridx;
   logic [4:0]  div_ff, nxt_div;
   logic        phase_ff, nxt_phase;
   logic [4:0]  rem1_ff, nxt_rem1, rem2_ff, nxt_rem2;
   logic        blank_ff, nxt_blank, d1_ff, nxt_d1, d2_ff, nxt_d2, dl_ff, nxt_dl;
   logic        pb_ff, nxt_pb, cl_ff, nxt_cl;

   cnt_mem_if mif ();
   area_count_mem u_mem (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .port    (mif.mem)
   );

   // true when pos equals any of the six toggle positions
   function automatic logic any_hit(input pos_t p, input pos_t t [`NUM_TOG]);
      any_hit = 1'b0;
      for (int i = 0; i < `NUM_TOG; i++) begin
         if (p == t[i]) any_hit = 1'b1;
      end
   endfunction : any_hit

   // write side of the register file
   always_comb begin
      nxt_mode = mode_ff;       nxt_mask = mask_ff;     nxt_stretch = stretch_ff;
      nxt_rstart = rstart_ff;   nxt_rend = rend_ff;     nxt_rlen = rlen_ff;
      nxt_rcnt = rcnt_ff;       nxt_sa = sa_ff;         nxt_sb = sb_ff;
      nxt_sc = sc_ff;           nxt_pon = pon_ff;       nxt_poff = poff_ff;
      nxt_con = con_ff;         nxt_coff = coff_ff;
      nxt_even_tog = even_tog_ff;
      nxt_odd_tog = odd_tog_ff;
      nxt_order = order_ff;
      if (reg_wr) begin
         case (reg_addr)
            `OFS_MODE:      nxt_mode = hblank_pkg::blank_mode_t'(reg_wdata[1:0]);
            `OFS_MASK:      nxt_mask = reg_wdata[2:0];
            `OFS_REP_START: nxt_rstart = reg_wdata[12:0];
            `OFS_REP_END:   nxt_rend = reg_wdata[12:0];
            `OFS_REP_LEN:   nxt_rlen = reg_wdata[12:0];
            `OFS_REP_COUNT: nxt_rcnt = reg_wdata[12:0];
            `OFS_STRETCH:   nxt_stretch = reg_wdata[`STRETCH_MSB:`STRETCH_LSB];
            `OFS_START_A:   nxt_sa = reg_wdata[12:0];
            `OFS_START_B:   nxt_sb = reg_wdata[12:0];
            `OFS_START_C:   nxt_sc = reg_wdata[12:0];
            `OFS_PIX_BLANK_ON:  nxt_pon = reg_wdata[12:0];
            `OFS_PIX_BLANK_OFF: nxt_poff = reg_wdata[12:0];
            `OFS_CLAMP_ON:  nxt_con = reg_wdata[12:0];
            `OFS_CLAMP_OFF: nxt_coff = reg_wdata[12:0];
            default: begin
               for (int i = 0; i < `NUM_TOG; i++) begin
                  if (reg_addr == `OFS_EVEN_TOG0 + 8'(i)) nxt_even_tog[i] = reg_wdata[12:0];
                  if (reg_addr == `OFS_ODD_TOG0 + 8'(i)) nxt_odd_tog[i] = reg_wdata[12:0];
                  if (reg_addr == `OFS_ODD_ORDER0 + 8'(i)) nxt_order[i] = reg_wdata[2:0];
               end
            end
         endcase
      end
   end

   // read side; unmapped and write-only addresses read zero
   always_comb begin
      nxt_rdata = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            `OFS_MODE:      nxt_rdata = {14'h0000, mode_ff};
            `OFS_MASK:      nxt_rdata = {13'h0000, mask_ff};
            `OFS_REP_START: nxt_rdata = {3'h0, rstart_ff};
            `OFS_REP_END:   nxt_rdata = {3'h0, rend_ff};
            `OFS_REP_LEN:   nxt_rdata = {3'h0, rlen_ff};
            `OFS_REP_COUNT: nxt_rdata = {3'h0, rcnt_ff};
            `OFS_STRETCH:   nxt_rdata = {8'h00, stretch_ff, 4'h0};
            `OFS_START_A:   nxt_rdata = {3'h0, sa_ff};
            `OFS_START_B:   nxt_rdata = {3'h0, sb_ff};
            `OFS_START_C:   nxt_rdata = {3'h0, sc_ff};
            `OFS_PIX_BLANK_ON:  nxt_rdata = {3'h0, pon_ff};
            `OFS_PIX_BLANK_OFF: nxt_rdata = {3'h0, poff_ff};
            `OFS_CLAMP_ON:  nxt_rdata = {3'h0, con_ff};
            `OFS_CLAMP_OFF: nxt_rdata = {3'h0, coff_ff};
            `OFS_STATUS:    nxt_rdata = {2'h0, odd_ff, hcnt_ff};
            default: begin
               for (int i = 0; i < `NUM_TOG; i++) begin
                  if (reg_addr == `OFS_EVEN_TOG0 + 8'(i)) nxt_rdata = {3'h0, even_tog_ff[i]};
                  if (reg_addr == `OFS_ODD_TOG0 + 8'(i)) nxt_rdata = {3'h0, odd_tog_ff[i]};
                  if (reg_addr == `OFS_ODD_ORDER0 + 8'(i)) nxt_rdata = {13'h0000, order_ff[i]};
               end
            end
         endcase
      end
   end

   // count words go straight into the memory; per area: driver 1 then driver 2
   logic [7:0]            cnt_ofs;
   logic [2:0]            area_eff;
   hblank_pkg::cnt_addr_t area_base;
   assign cnt_ofs  = reg_addr - `OFS_COUNT0;
   assign area_eff = (odd_ff && ridx_ff < 13'(`NUM_AREA)) ? order_ff[ridx_ff[2:0]]
                                                       : ridx_ff[2:0];
   assign area_base = (ridx_ff < 13'(`NUM_AREA)) ? {area_eff, 1'b0} : 4'hf;
   assign mif.wr_en    = reg_wr && reg_addr >= `OFS_COUNT0 && cnt_ofs < 8'(`NUM_CNT_WORDS);
   assign mif.wr_addr  = cnt_ofs[3:0];
   assign mif.wr_data  = reg_wdata[11:0];
   assign mif.rd_addr1 = area_base;
   assign mif.rd_addr2 = (area_base == 4'hf) ? 4'hf : area_base | 4'h1;

   // derived terms of the current pixel
   logic in_rgn, blank_now, adv, wide, rep_wrap;
   logic [3:0] c1, c2;
   pos_t tog_set [`NUM_TOG];
   always_comb begin
      adv       = (mode_ff == hblank_pkg::MODE_ADVANCED);
      in_rgn    = (hcnt_ff >= rstart_ff) && (hcnt_ff < rend_ff);
      tog_set   = odd_ff ? odd_tog_ff : even_tog_ff;
      blank_now = (mode_ff == hblank_pkg::MODE_NORMAL) ? tog_ff : in_rgn;
      wide      = blank_now && !adv && (stretch_ff != 4'h0);
      rep_wrap  = (rpos_ff + 13'h0001 >= rlen_ff);
      c1 = 4'h0;
      c2 = 4'h0;
      // pick the group count following the start that matches here
      if (rpos_ff == sa_ff) begin
         c1 = mif.rd_data1[`CNT_A_LSB +: 4];
         c2 = mif.rd_data2[`CNT_A_LSB +: 4];
      end else if (rpos_ff == sb_ff) begin
         c1 = mif.rd_data1[`CNT_B_LSB +: 4];
         c2 = mif.rd_data2[`CNT_B_LSB +: 4];
      end else if (rpos_ff == sc_ff) begin
         c1 = mif.rd_data1[`CNT_C_LSB +: 4];
         c2 = mif.rd_data2[`CNT_C_LSB +: 4];
      end
   end

   // counter, line parity, toggle state and repeat tracking
   always_comb begin
      nxt_sync_d = line_sync;
      nxt_dly    = dly_ff;
      nxt_hcnt   = hcnt_ff + 13'h0001;
      nxt_odd    = odd_ff;
      nxt_tog    = tog_ff ^ any_hit(hcnt_ff, tog_set);
      nxt_rpos   = rpos_ff;
      nxt_ridx   = ridx_ff;
      // the counter only restarts after the pipeline delay
      if (sync_d_ff && !line_sync) begin
         nxt_dly = 4'h1;
      end else if (dly_ff == `PIPE_DLY) begin
         nxt_dly  = 4'h0;
         nxt_hcnt = `RST_POS;
         nxt_odd  = !odd_ff;
         nxt_tog  = 1'b0;
      end else if (dly_ff != 4'h0) begin
         nxt_dly = dly_ff + 4'h1;
      end
      // repeat phase restarts at the region start, wraps every length
      if (hcnt_ff + 13'h0001 == rstart_ff) begin
         nxt_rpos = `RST_POS;
         nxt_ridx = `RST_POS;
      end else if (in_rgn) begin
         nxt_rpos = rep_wrap ? `RST_POS : rpos_ff + 13'h0001;
         nxt_ridx = rep_wrap ? ridx_ff + 13'h0001 : ridx_ff;
      end
   end

   // clock phase and advanced-mode pulse groups
   always_comb begin
      nxt_div   = 5'h00;
      nxt_phase = !phase_ff;
      // widened clocks hold each level 2n pixels, giving 1/(4n) of pixel rate
      if (wide && (div_ff + 5'h01) < {stretch_ff, 1'b0}) begin
         nxt_div   = div_ff + 5'h01;
         nxt_phase = phase_ff;
      end
      nxt_rem1 = (rem1_ff != 5'h00) ? rem1_ff - 5'h01 : 5'h00;
      nxt_rem2 = (rem2_ff != 5'h00) ? rem2_ff - 5'h01 : 5'h00;
      if (adv && in_rgn && ridx_ff < 13'(`NUM_AREA)) begin
         if (c1 != 4'h0) nxt_rem1 = {c1, 1'b0};
         if (c2 != 4'h0) nxt_rem2 = {c2, 1'b0};
      end
   end

   // output levels
   always_comb begin
      nxt_blank = blank_now;
      nxt_d1    = phase_ff;
      nxt_d2    = !phase_ff;
      nxt_dl    = !phase_ff;
      nxt_pb    = (hcnt_ff == pon_ff) ? 1'b1 : (hcnt_ff == poff_ff) ? 1'b0 : pb_ff;
      nxt_cl    = (hcnt_ff == con_ff) ? 1'b1 : (hcnt_ff == coff_ff) ? 1'b0 : cl_ff;
      if (blank_now) begin
         case (mode_ff)
            hblank_pkg::MODE_ADVANCED: begin
               // even remainder is the high half of each pulse
               nxt_d1 = (rem1_ff != 5'h00) ? !rem1_ff[0] : mask_ff[`MASK_DRV1_BIT];
               nxt_d2 = (rem2_ff != 5'h00) ? !rem2_ff[0] : mask_ff[`MASK_DRV2_BIT];
               nxt_dl = (rem2_ff != 5'h00) ? !rem2_ff[0] : mask_ff[`MASK_LAST_BIT];
            end
            hblank_pkg::MODE_REPEAT: begin
               // pulses only inside toggle windows of the first count repeats
               if (!(tog_ff && ridx_ff < rcnt_ff)) begin
                  nxt_d1 = mask_ff[`MASK_DRV1_BIT];
                  nxt_d2 = mask_ff[`MASK_DRV2_BIT];
                  nxt_dl = mask_ff[`MASK_LAST_BIT];
               end
            end
            default: begin
               // normal mode masks the interval unless wide clocks are asked for
               if (!wide) begin
                  nxt_d1 = mask_ff[`MASK_DRV1_BIT];
                  nxt_d2 = mask_ff[`MASK_DRV2_BIT];
                  nxt_dl = mask_ff[`MASK_LAST_BIT];
               end
            end
         endcase
      end
   end

   // mode 1 toggle state runs on the repeat phase, not the line counter
   logic tog_src_rep;
   assign tog_src_rep = (mode_ff == hblank_pkg::MODE_REPEAT);
   logic nxt_tog_eff;
   always_comb begin
      nxt_tog_eff = nxt_tog;
      if (tog_src_rep) begin
         nxt_tog_eff = (nxt_rpos == `RST_POS && in_rgn == 1'b0) ? 1'b0
                     : tog_ff ^ any_hit(rpos_ff, tog_set);
         if (in_rgn && rep_wrap) nxt_tog_eff = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         mode_ff <= hblank_pkg::MODE_NORMAL;  mask_ff <= `RST_MASK;  stretch_ff <= `RST_STRETCH;
         rstart_ff <= `RST_POS;  rend_ff <= `RST_POS;  rlen_ff <= `RST_POS;  rcnt_ff <= `RST_POS;
         sa_ff <= `RST_POS;  sb_ff <= `RST_POS;  sc_ff <= `RST_POS;
         pon_ff <= `RST_POS;  poff_ff <= `RST_POS;  con_ff <= `RST_POS;  coff_ff <= `RST_POS;
         for (int i = 0; i < `NUM_TOG; i++) begin
            even_tog_ff[i] <= `RST_POS;
            odd_tog_ff[i]  <= `RST_POS;
            order_ff[i]    <= 3'(i);
         end
         rdata_ff <= 16'h0000;  sync_d_ff <= 1'b0;  dly_ff <= 4'h0;  hcnt_ff <= `RST_POS;
         odd_ff <= 1'b1;  tog_ff <= 1'b0;  rpos_ff <= `RST_POS;  ridx_ff <= 13'h1fff;
         div_ff <= 5'h00;  phase_ff <= 1'b0;  rem1_ff <= 5'h00;  rem2_ff <= 5'h00;
         blank_ff <= 1'b0;  d1_ff <= 1'b0;  d2_ff <= 1'b0;  dl_ff <= 1'b0;
         pb_ff <= 1'b0;  cl_ff <= 1'b0;
      end else begin
         mode_ff <= nxt_mode;  mask_ff <= nxt_mask;  stretch_ff <= nxt_stretch;
         rstart_ff <= nxt_rstart;  rend_ff <= nxt_rend;  rlen_ff <= nxt_rlen;  rcnt_ff <= nxt_rcnt;
         sa_ff <= nxt_sa;  sb_ff <= nxt_sb;  sc_ff <= nxt_sc;
         pon_ff <= nxt_pon;  poff_ff <= nxt_poff;  con_ff <= nxt_con;  coff_ff <= nxt_coff;
         even_tog_ff <= nxt_even_tog;
         odd_tog_ff  <= nxt_odd_tog;
         order_ff    <= nxt_order;
         rdata_ff <= nxt_rdata;  sync_d_ff <= nxt_sync_d;  dly_ff <= nxt_dly;  hcnt_ff <= nxt_hcnt;
         odd_ff <= nxt_odd;  tog_ff <= nxt_tog_eff;  rpos_ff <= nxt_rpos;  ridx_ff <= nxt_ridx;
         div_ff <= nxt_div;  phase_ff <= nxt_phase;  rem1_ff <= nxt_rem1;  rem2_ff <= nxt_rem2;
         blank_ff <= nxt_blank;  d1_ff <= nxt_d1;  d2_ff <= nxt_d2;  dl_ff <= nxt_dl;
         pb_ff <= nxt_pb;  cl_ff <= nxt_cl;
      end
   end

   assign reg_rdata           = rdata_ff;
   assign horizontal_blank    = blank_ff;
   assign horizontal_driver_1 = d1_ff;
   assign horizontal_driver_2 = d2_ff;
   assign last_stage_driver   = dl_ff;
   assign pixel_blank         = pb_ff;
   assign black_clamp         = cl_ff;
endmodule : hblank_gen

// ===== test/hblank_gen_asserts.sv
// port assertions for the blanking generator
module hblank_gen_asserts (
   input wire logic        sys_clk,             // pixel clock
   input wire logic        sys_rst,             // reset
   input wire logic        line_sync,           // line sync
   input wire logic        reg_wr,              // write strobe
   input wire logic        reg_rd,              // read strobe
   input wire logic [7:0]  reg_addr,            // address
   input wire logic [15:0] reg_wdata,           // write data
   input wire logic [15:0] reg_rdata,           // read data
   input wire logic        horizontal_blank,    // blanking
   input wire logic        horizontal_driver_1, // driver 1
   input wire logic        horizontal_driver_2, // driver 2
   input wire logic        last_stage_driver,   // last stage
   input wire logic        pixel_blank,         // pixel blank
   input wire logic        black_clamp          // clamp
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // stretch write, idle cycle, stretch read
   sequence stretch_wr_rd;
      reg_wr && reg_addr == 8'h34 ##1 !reg_wr ##1 reg_rd && !reg_wr && reg_addr == 8'h34;
   endsequence
   // three pixels clear of blanking
   sequence open_run;
      !horizontal_blank [*3];
   endsequence
   chk_stretch_keep: assert property (stretch_wr_rd |=>
      reg_rdata == {8'h00, $past(reg_wdata[7:4], 3), 4'h0}) else $error("stretch lost");
   chk_stretch_bits: assert property (reg_rd && reg_addr == 8'h34 |=>
      reg_rdata[15:8] == 8'h00 && reg_rdata[3:0] == 4'h0) else $error("stretch spill");
   chk_count_wonly: assert property (reg_rd && reg_addr == 8'h60 |=>
      reg_rdata == 16'h0000) else $error("count word readable");
   chk_rdata_rest: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data without read");
   chk_open_rate: assert property (open_run |->
      horizontal_driver_1 != $past(horizontal_driver_1)) else $error("slow open clock");
   chk_open_pair: assert property (open_run |->
      horizontal_driver_2 == !horizontal_driver_1) else $error("driver 2 not inverse");
   chk_open_last: assert property (open_run |->
      last_stage_driver == horizontal_driver_2) else $error("last stage off phase");
   chk_reset_quiet: assert property ($fell(sys_rst) |->
      !horizontal_blank && !pixel_blank && !black_clamp) else $error("outputs after reset");
endmodule : hblank_gen_asserts

bind hblank_gen hblank_gen_asserts hblank_gen_asserts_i (.*);

// ===== test/ccd_hshift_model.sv
// behavioural ccd horizontal register counting shifts during blanking
module ccd_hshift_model (
   input wire logic sys_clk,   // pixel clock
   input wire logic line_sync, // high clears the counts
   input wire logic blank,     // blanking interval
   input wire logic drv1,      // driver 1
   input wire logic drv2,      // driver 2
   output int       shifts1,   // driver 1 rises in blanking
   output int       shifts2    // driver 2 rises in blanking
);
   timeunit 1ns;
   timeprecision 1ps;
   logic d1_ff = 1'b0;
   logic d2_ff = 1'b0;
   // one charge packet moves per rising driver edge
   always @(posedge sys_clk) begin
      d1_ff <= drv1;
      d2_ff <= drv2;
      if (line_sync) begin
         shifts1 <= 0;
         shifts2 <= 0;
      end else if (blank) begin
         shifts1 <= shifts1 + int'(drv1 && !d1_ff);
         shifts2 <= shifts2 + int'(drv2 && !d2_ff);
      end
   end
endmodule : ccd_hshift_model

// ===== test/hblank_gen_tb_top.sv
// self-checking bench for the blanking generator
`include "hblank_regs.svh"
module hblank_gen_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0, sys_rst = 1'b1, line_sync = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, v;
   logic        horizontal_blank, horizontal_driver_1, horizontal_driver_2;
   logic        last_stage_driver, pixel_blank, black_clamp;
   int          num_errors = 0, tests_run = 0, cyc = 0, e0 = 0, k, shifts1, shifts2;
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) cyc <= cyc + 1;
   hblank_gen hblank_gen_i (.*);
   ccd_hshift_model ccd_hshift_model_i (.sys_clk(sys_clk), .line_sync(line_sync),
      .blank(horizontal_blank), .drv1(horizontal_driver_1), .drv2(horizontal_driver_2),
      .shifts1(shifts1), .shifts2(shifts2));
   task automatic chk(input string what, input logic [15:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   // one-cycle sync pulse; e0 marks the edge that sees it fall
   task automatic new_line();
      @(posedge sys_clk);
      line_sync <= 1'b1;
      @(posedge sys_clk);
      line_sync <= 1'b0;
      @(posedge sys_clk);
      #1 e0 = cyc;
   endtask : new_line
   // settle just after output for counter position p has moved
   task automatic wait_to(input int p);
      while (cyc - e0 < `PIPE_DLY + p + 1) begin
         @(posedge sys_clk);
         #1;
      end
   endtask : wait_to
   task automatic flips(input int n);
      logic prev;
      k = 0;
      prev = horizontal_driver_1;
      repeat (n) begin
         @(posedge sys_clk);
         #1 k += int'(horizontal_driver_1 !== prev);
         prev = horizontal_driver_1;
      end
   endtask : flips
   task automatic close_out();
      $display("comparisons %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out
   // hang guard, far beyond the roughly 1200 cycles the run needs
   initial begin
      #40us;
      num_errors++;
      close_out();
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(8'h34);
      chk("stretch reset", v, 16'h0000);
      wr(8'h34, 16'hffff);
      rd(8'h34);
      chk("stretch field", v, 16'h00f0);
      wr(8'h60, 16'h0fff);
      rd(8'h60);
      chk("count word", v, 16'h0000);
      rd(8'h7e);
      chk("unmapped", v, 16'h0000);
      // positions written as the counter values the checks wait for; spare toggles parked far off
      for (int i = 0; i < 6; i++) begin
         wr(8'h10 + 8'(i), i == 0 ? 16'h0028 : i == 1 ? 16'h0050 : 16'h1fff);
         wr(8'h18 + 8'(i), i == 0 ? 16'h0032 : i == 1 ? 16'h0050 : 16'h1fff);
      end
      wr(8'h34, 16'h0020);
      wr(8'h40, 16'h0014);
      wr(8'h42, 16'h0064);
      wr(8'h44, 16'h003c);
      wr(8'h46, 16'h0046);
      // pixel blank and clamp latch high at position 0 after reset and are only
      // cleared at their off positions; two settling lines keep parity even
      repeat (2) begin
         new_line();
         wait_to(101);
      end
      new_line();
      wait_to(19);
      chk("pixel blank early", pixel_blank, 16'h0000);
      wait_to(20);
      chk("pixel blank on", pixel_blank, 16'h0001);
      wait_to(45);
      chk("even blank", horizontal_blank, 16'h0001);
      wait_to(48);
      flips(16);
      chk("wide clock flips", 16'(k), 16'h0004);
      wait_to(66);
      chk("clamp", black_clamp, 16'h0001);
      wait_to(90);
      chk("blank end", horizontal_blank, 16'h0000);
      wait_to(101);
      flips(16);
      chk("open clock flips", 16'(k), 16'h0010);
      new_line();
      wait_to(45);
      chk("odd blank late", horizontal_blank, 16'h0000);
      wait_to(55);
      chk("odd blank", horizontal_blank, 16'h0001);
      // advanced mode: areas of 50 from 100, only group A of area 0 pulses
      wr(8'h00, 16'h0002);
      wr(8'h04, 16'h0064);
      wr(8'h06, 16'h00c8);
      wr(8'h08, 16'h0032);
      wr(8'h38, 16'h0005);
      wr(8'h3a, 16'h0014);
      wr(8'h3c, 16'h001e);
      wr(8'h60, 16'h0003);
      wr(8'h61, 16'h0001);
      wr(8'h50, 16'h0001);
      new_line();
      wait_to(220);
      chk("area drv1", 16'(shifts1), 16'h0003);
      chk("area drv2", 16'(shifts2), 16'h0001);
      new_line();
      wait_to(220);
      chk("odd area drv1", 16'(shifts1), 16'h0000);
      chk("odd area drv2", 16'(shifts2), 16'h0000);
      // mode 1: window on repeat phase 41..44, first repeat only, stretch 2
      // puts exactly one level change of each driver inside the window
      wr(8'h00, 16'h0001);
      wr(8'h0a, 16'h0001);
      wr(8'h11, 16'h002c);
      new_line();
      wait_to(150);
      chk("repeat blank", horizontal_blank, 16'h0001);
      wait_to(220);
      chk("repeat drv1", 16'(shifts1), 16'h0001);
      chk("repeat drv2", 16'(shifts2), 16'h0001);
      close_out();
   end
endmodule : hblank_gen_tb_top
